// *** common/ppfm_pkg.sv ***
// Functional notes
// - mode from three static mode-select pins, caught after reset release.
// - port0 pull-up applies only while pin is input.
// - port1 pull-up applies only while pin is input.
// - bus mode: port0 carries low address, muxed with low data byte.
// - bus mode: port1 carries middle address, muxed with high data byte.
// - bus mode: port2 drives upper address bits 16 to 23.
// - bus mode: port3 bit0 is address latch enable output.
// - bus mode: port3 bit1 is active-low read strobe.
// - bus mode: port3 bits 2,3 are low and high byte write strobes.
// - bus mode: port3 bit4 hold request in, bit5 hold acknowledge out.
// - bus mode: port3 bit6 is ready input from external devices.
// - bus mode: port3 bit7 outputs the bus clock.
// - each port4 pin selectable push-pull or open drain while used as port pin; peripheral outputs drive push-pull.
// - async tx pin overridden only while tx output enabled.
// - async clock pin driven only while clock output enabled.
// - pulse outputs on port4 bits 6,7 only when enabled.
// - sync serial takes data and clock pins when data output enabled.
// - port6 pull-up applies only while pin is input.
// - clock monitor on port6 bit3 only when enabled.
// - port5 bits 6,7 always feed capture trigger inputs.
package ppfm_pkg;
  localparam int PPFM_W = 8;
  localparam logic [2:0] PPFM_MODE_SINGLE = 3'h0;
  localparam int P3_ALE = 0;
  localparam int P3_RD = 1;
  localparam int P3_WRL = 2;
  localparam int P3_WRH = 3;
  localparam int P3_HREQ = 4;
  localparam int P3_HACK = 5;
  localparam int P3_RDY = 6;
  localparam int P3_CLK = 7;
  localparam int P4_A0_RX = 0;
  localparam int P4_A1_RX = 3;
  localparam int P4_A0_TX = 1;
  localparam int P4_A0_CK = 2;
  localparam int P4_A1_TX = 4;
  localparam int P4_A1_CK = 5;
  localparam int P4_PG0 = 6;
  localparam int P4_PG1 = 7;
  localparam int P5_S0_TX = 1;
  localparam int P5_S0_CK = 2;
  localparam int P5_S1_TX = 4;
  localparam int P5_S1_CK = 5;
  localparam int P5_CAP0 = 6;
  localparam int P5_CAP1 = 7;
  localparam int P6_S2_TX = 1;
  localparam int P6_S2_CK = 2;
  localparam int P6_CKMON = 3;
  localparam logic [7:0] PPFM_ZERO8 = 8'h00;
endpackage

// *** logic/ppfm_pin_cell.sv ***
`timescale 1ns/10ps
// one pad's output drive; oe_n low means driving
module ppfm_pin_cell (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sel_alt,
  input wire logic alt_val,
  input wire logic alt_drv,
  input wire logic gpio_val,
  input wire logic gpio_dir,
  input wire logic pull_sel,
  input wire logic od_sel,
  output logic out_reg,
  output logic oe_n_reg,
  output logic pull_reg
);
  logic val;
  logic drv;
  // ***************************************
  // output select
  // ***************************************
  always_comb begin
    val = gpio_val;
    drv = gpio_dir;
    if (sel_alt) begin
      val = alt_val;
      drv = alt_drv;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_reg <= 1'b0;
      oe_n_reg <= 1'b1;
      pull_reg <= 1'b0;
    end else begin
      out_reg <= val;
      oe_n_reg <= !(drv && !(od_sel && val));
      pull_reg <= pull_sel && !drv;
    end
  end
endmodule

// *** logic/ppfm_top.sv ***
`timescale 1ns/10ps
module ppfm_top import ppfm_pkg::*; #(
  parameter int W = PPFM_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] mode_select_pins,
  input wire logic [W-1:0] p0_in,
  input wire logic [W-1:0] p1_in,
  input wire logic [W-1:0] p3_in,
  input wire logic [W-1:0] p4_in,
  input wire logic [W-1:0] p5_in,
  input wire logic [W-1:0] p6_in,
  input wire logic [W-1:0] p0_data,
  input wire logic [W-1:0] p0_dir,
  input wire logic [W-1:0] p1_data,
  input wire logic [W-1:0] p1_dir,
  input wire logic [W-1:0] p2_data,
  input wire logic [W-1:0] p2_dir,
  input wire logic [W-1:0] p3_data,
  input wire logic [W-1:0] p3_dir,
  input wire logic [W-1:0] p4_data,
  input wire logic [W-1:0] p4_dir,
  input wire logic [W-1:0] p5_data,
  input wire logic [W-1:0] p5_dir,
  input wire logic [W-1:0] p6_data,
  input wire logic [W-1:0] p6_dir,
  input wire logic [W-1:0] port0_pullup_select,
  input wire logic [W-1:0] port1_pullup_select,
  input wire logic [W-1:0] port6_pullup_select,
  input wire logic [W-1:0] port4_open_drain_select,
  input wire logic [23:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic bus_addr_phase,
  input wire logic bus_data_drive,
  input wire logic bus_ale,
  input wire logic bus_rd_n,
  input wire logic bus_wrl_n,
  input wire logic bus_wrh_n,
  input wire logic bus_hold_ack,
  input wire logic bus_clk_out,
  input wire logic [1:0] async_serial_tx,
  input wire logic [1:0] async_tx_en,
  input wire logic [1:0] async_serial_clock,
  input wire logic [1:0] async_clk_out_en,
  input wire logic [2:0] sync_serial_tx,
  input wire logic [2:0] sync_serial_clock,
  input wire logic [2:0] sync_tx_en,
  input wire logic [1:0] pulse_gen_outputs,
  input wire logic [1:0] pulse_out_en,
  input wire logic clock_monitor_out,
  input wire logic clock_monitor_en,
  output logic ext_bus_mode,
  output logic [15:0] bus_rdata,
  output logic bus_hold_request,
  output logic bus_ready,
  output logic [1:0] async_serial_rx,
  output logic [1:0] async_clock_in,
  output logic [1:0] capture_trigger_inputs,
  output logic [W-1:0] p0_out,
  output logic [W-1:0] p0_oe_n,
  output logic [W-1:0] p0_pull,
  output logic [W-1:0] p1_out,
  output logic [W-1:0] p1_oe_n,
  output logic [W-1:0] p1_pull,
  output logic [W-1:0] p2_out,
  output logic [W-1:0] p2_oe_n,
  output logic [W-1:0] p3_out,
  output logic [W-1:0] p3_oe_n,
  output logic [W-1:0] p4_out,
  output logic [W-1:0] p4_oe_n,
  output logic [W-1:0] p5_out,
  output logic [W-1:0] p5_oe_n,
  output logic [W-1:0] p6_out,
  output logic [W-1:0] p6_oe_n,
  output logic [W-1:0] p6_pull
);
  // ***************************************
  // mode capture
  // ***************************************
  logic mode_cap_done;
  logic bus_mode;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_cap_done <= 1'b0;
      bus_mode <= 1'b0;
    end else if (!mode_cap_done) begin
      mode_cap_done <= 1'b1;
      bus_mode <= (mode_select_pins != PPFM_MODE_SINGLE);
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ext_bus_mode <= 1'b0;
    end else begin
      ext_bus_mode <= bus_mode;
    end
  end

  // ***************************************
  // alternate selection per port
  // ***************************************
  logic [W-1:0] sel0, val0, drv0;
  logic [W-1:0] sel1, val1, drv1;
  logic [W-1:0] sel2, val2, drv2;
  logic [W-1:0] sel3, val3, drv3;
  logic [W-1:0] sel4, val4, drv4;
  logic [W-1:0] sel5, val5, drv5;
  logic [W-1:0] sel6, val6, drv6;
  logic [W-1:0] p4_od_eff;
  always_comb begin
    sel0 = {W{bus_mode}};
    val0 = bus_addr_phase ? bus_addr[7:0] : bus_wdata[7:0];
    drv0 = {W{bus_addr_phase || bus_data_drive}};
    sel1 = {W{bus_mode}};
    val1 = bus_addr_phase ? bus_addr[15:8] : bus_wdata[15:8];
    drv1 = {W{bus_addr_phase || bus_data_drive}};
    sel2 = {W{bus_mode}};
    val2 = bus_addr[23:16];
    drv2 = {W{1'b1}};
    sel3 = {W{bus_mode}};
    val3 = PPFM_ZERO8;
    drv3 = {W{1'b1}};
    val3[P3_ALE] = bus_ale;
    val3[P3_RD] = bus_rd_n;
    val3[P3_WRL] = bus_wrl_n;
    val3[P3_WRH] = bus_wrh_n;
    drv3[P3_HREQ] = 1'b0;
    val3[P3_HACK] = bus_hold_ack;
    drv3[P3_RDY] = 1'b0;
    val3[P3_CLK] = bus_clk_out;
    sel4 = PPFM_ZERO8;
    val4 = PPFM_ZERO8;
    drv4 = {W{1'b1}};
    sel4[P4_A0_TX] = async_tx_en[0];
    val4[P4_A0_TX] = async_serial_tx[0];
    sel4[P4_A1_TX] = async_tx_en[1];
    val4[P4_A1_TX] = async_serial_tx[1];
    sel4[P4_A0_CK] = async_clk_out_en[0];
    val4[P4_A0_CK] = async_serial_clock[0];
    sel4[P4_A1_CK] = async_clk_out_en[1];
    val4[P4_A1_CK] = async_serial_clock[1];
    sel4[P4_PG0] = pulse_out_en[0];
    val4[P4_PG0] = pulse_gen_outputs[0];
    sel4[P4_PG1] = pulse_out_en[1];
    val4[P4_PG1] = pulse_gen_outputs[1];
    sel5 = PPFM_ZERO8;
    val5 = PPFM_ZERO8;
    drv5 = {W{1'b1}};
    sel5[P5_S0_TX] = sync_tx_en[0];
    val5[P5_S0_TX] = sync_serial_tx[0];
    sel5[P5_S0_CK] = sync_tx_en[0];
    val5[P5_S0_CK] = sync_serial_clock[0];
    sel5[P5_S1_TX] = sync_tx_en[1];
    val5[P5_S1_TX] = sync_serial_tx[1];
    sel5[P5_S1_CK] = sync_tx_en[1];
    val5[P5_S1_CK] = sync_serial_clock[1];
    sel6 = PPFM_ZERO8;
    val6 = PPFM_ZERO8;
    drv6 = {W{1'b1}};
    sel6[P6_S2_TX] = sync_tx_en[2];
    val6[P6_S2_TX] = sync_serial_tx[2];
    sel6[P6_S2_CK] = sync_tx_en[2];
    val6[P6_S2_CK] = sync_serial_clock[2];
    sel6[P6_CKMON] = clock_monitor_en;
    val6[P6_CKMON] = clock_monitor_out;
    // open drain is a port-mode feature; peripherals drive push-pull
    p4_od_eff = port4_open_drain_select & ~sel4;
  end

  // ***************************************
  // pad cells
  // ***************************************
  logic [W-1:0] pu1_r, pu0_r, pu6_r;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_pad
      ppfm_pin_cell u0 (
        .clk(clk),
        .rst_n(rst_n),
        .sel_alt(sel0[i]),
        .alt_val(val0[i]),
        .alt_drv(drv0[i]),
        .gpio_val(p0_data[i]),
        .gpio_dir(p0_dir[i]),
        .pull_sel(port0_pullup_select[i] && !bus_mode),
        .od_sel(1'b0),
        .out_reg(p0_out[i]),
        .oe_n_reg(p0_oe_n[i]),
        .pull_reg(pu0_r[i])
      );
      ppfm_pin_cell u1 (
        .clk(clk),
        .rst_n(rst_n),
        .sel_alt(sel1[i]),
        .alt_val(val1[i]),
        .alt_drv(drv1[i]),
        .gpio_val(p1_data[i]),
        .gpio_dir(p1_dir[i]),
        .pull_sel(port1_pullup_select[i] && !bus_mode),
        .od_sel(1'b0),
        .out_reg(p1_out[i]),
        .oe_n_reg(p1_oe_n[i]),
        .pull_reg(pu1_r[i])
      );
      ppfm_pin_cell u2 (
        .clk(clk),
        .rst_n(rst_n),
        .sel_alt(sel2[i]),
        .alt_val(val2[i]),
        .alt_drv(drv2[i]),
        .gpio_val(p2_data[i]),
        .gpio_dir(p2_dir[i]),
        .pull_sel(1'b0),
        .od_sel(1'b0),
        .out_reg(p2_out[i]),
        .oe_n_reg(p2_oe_n[i]),
        .pull_reg()
      );
      ppfm_pin_cell u3 (
        .clk(clk),
        .rst_n(rst_n),
        .sel_alt(sel3[i]),
        .alt_val(val3[i]),
        .alt_drv(drv3[i]),
        .gpio_val(p3_data[i]),
        .gpio_dir(p3_dir[i]),
        .pull_sel(1'b0),
        .od_sel(1'b0),
        .out_reg(p3_out[i]),
        .oe_n_reg(p3_oe_n[i]),
        .pull_reg()
      );
      ppfm_pin_cell u4 (
        .clk(clk),
        .rst_n(rst_n),
        .sel_alt(sel4[i]),
        .alt_val(val4[i]),
        .alt_drv(drv4[i]),
        .gpio_val(p4_data[i]),
        .gpio_dir(p4_dir[i]),
        .pull_sel(1'b0),
        .od_sel(p4_od_eff[i]),
        .out_reg(p4_out[i]),
        .oe_n_reg(p4_oe_n[i]),
        .pull_reg()
      );
      ppfm_pin_cell u5 (
        .clk(clk),
        .rst_n(rst_n),
        .sel_alt(sel5[i]),
        .alt_val(val5[i]),
        .alt_drv(drv5[i]),
        .gpio_val(p5_data[i]),
        .gpio_dir(p5_dir[i]),
        .pull_sel(1'b0),
        .od_sel(1'b0),
        .out_reg(p5_out[i]),
        .oe_n_reg(p5_oe_n[i]),
        .pull_reg()
      );
      ppfm_pin_cell u6 (
        .clk(clk),
        .rst_n(rst_n),
        .sel_alt(sel6[i]),
        .alt_val(val6[i]),
        .alt_drv(drv6[i]),
        .gpio_val(p6_data[i]),
        .gpio_dir(p6_dir[i]),
        .pull_sel(port6_pullup_select[i]),
        .od_sel(1'b0),
        .out_reg(p6_out[i]),
        .oe_n_reg(p6_oe_n[i]),
        .pull_reg(pu6_r[i])
      );
    end
  endgenerate
  assign p0_pull = pu0_r;
  assign p1_pull = pu1_r;
  assign p6_pull = pu6_r;

  // ***************************************
  // inputs toward the core and peripherals
  // ***************************************
  // inputs are registered: one cycle of latency, no metastability filter
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_rdata <= 16'h0000;
    end else begin
      bus_rdata <= {p1_in, p0_in};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_hold_request <= 1'b0;
    end else begin
      bus_hold_request <= bus_mode && p3_in[P3_HREQ];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bus_ready <= 1'b0;
    end else begin
      bus_ready <= bus_mode && p3_in[P3_RDY];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      async_serial_rx <= 2'h0;
      async_clock_in <= 2'h0;
    end else begin
      async_serial_rx <= {p4_in[P4_A1_RX], p4_in[P4_A0_RX]};
      async_clock_in <= {p4_in[P4_A1_CK], p4_in[P4_A0_CK]};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      capture_trigger_inputs <= 2'h0;
    end else begin
      capture_trigger_inputs <= {p5_in[P5_CAP1], p5_in[P5_CAP0]};
    end
  end
endmodule

// *** verif/ppfm_assertions.sv ***
`timescale 1ns/10ps
// ****
// pad mux checker
// ****
module ppfm_assertions import ppfm_pkg::*; #(
  parameter int W = PPFM_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ext_bus_mode,
  input wire logic bus_addr_phase,
  input wire logic bus_data_drive,
  input wire logic bus_ale,
  input wire logic bus_rd_n,
  input wire logic bus_wrl_n,
  input wire logic bus_wrh_n,
  input wire logic bus_hold_ack,
  input wire logic bus_clk_out,
  input wire logic bus_hold_request,
  input wire logic bus_ready,
  input wire logic [23:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic [1:0] async_serial_tx,
  input wire logic [1:0] async_tx_en,
  input wire logic [1:0] pulse_gen_outputs,
  input wire logic [1:0] pulse_out_en,
  input wire logic [1:0] capture_trigger_inputs,
  input wire logic [W-1:0] p0_out,
  input wire logic [W-1:0] p0_oe_n,
  input wire logic [W-1:0] p1_out,
  input wire logic [W-1:0] p1_oe_n,
  input wire logic [W-1:0] p2_out,
  input wire logic [W-1:0] p2_oe_n,
  input wire logic [W-1:0] p2_data,
  input wire logic [W-1:0] p2_dir,
  input wire logic [W-1:0] p3_in,
  input wire logic [W-1:0] p3_out,
  input wire logic [W-1:0] p3_oe_n,
  input wire logic [W-1:0] p4_out,
  input wire logic [W-1:0] p4_oe_n,
  input wire logic [W-1:0] p5_in
);
  // strap is trusted only a few edges after release
  logic [1:0] up_reg;
  logic ok;
  always_ff @(posedge clk) begin
    if (!rst_n) up_reg <= 2'h0;
    else if (!ok) up_reg <= up_reg + 2'h1;
  end
  assign ok = up_reg == 2'h3;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  mode_hold_a: assert property (ok |-> $stable(ext_bus_mode))
    else $error("mode moved");
  addr_phase_a: assert property (ok && ext_bus_mode && bus_addr_phase |=>
    {p1_oe_n, p0_oe_n} == 16'h0000 && {p1_out, p0_out} == $past(bus_addr[15:0]))
    else $error("addr phase");
  data_phase_a: assert property (ok && ext_bus_mode && !bus_addr_phase &&
    bus_data_drive |=> {p1_out, p0_out} == $past(bus_wdata) && p1_oe_n == 8'h00)
    else $error("data phase");
  upper_addr_a: assert property (ok && ext_bus_mode |=> p2_oe_n == 8'h00 &&
    p2_out == $past(bus_addr[23:16])) else $error("upper addr");
  latch_read_a: assert property (ok && ext_bus_mode |=> p3_oe_n[1:0] == 2'h0 &&
    p3_out[0] == $past(bus_ale) && p3_out[1] == $past(bus_rd_n)) else $error("ale rd");
  write_strobe_a: assert property (ok && ext_bus_mode |=> p3_oe_n[3:2] == 2'h0 &&
    p3_out[2] == $past(bus_wrl_n) && p3_out[3] == $past(bus_wrh_n)) else $error("wr");
  hold_pair_a: assert property (ok && ext_bus_mode |=> p3_oe_n[4] &&
    bus_hold_request == $past(p3_in[4]) && p3_out[5] == $past(bus_hold_ack))
    else $error("hold");
  ready_in_a: assert property (ok |=>
    bus_ready == ($past(p3_in[6]) && $past(ext_bus_mode))) else $error("ready");
  bus_clock_a: assert property (ok && ext_bus_mode |=> !p3_oe_n[7] &&
    p3_out[7] == $past(bus_clk_out)) else $error("bus clock");
  async_tx_a: assert property (ok && async_tx_en[0] |=> !p4_oe_n[1] &&
    p4_out[1] == $past(async_serial_tx[0])) else $error("async tx");
  pulse_out_a: assert property (ok && pulse_out_en[1] |=> !p4_oe_n[7] &&
    p4_out[7] == $past(pulse_gen_outputs[1])) else $error("pulse");
  capture_in_a: assert property (ok |=>
    capture_trigger_inputs == $past(p5_in[7:6])) else $error("capture");
  gpio_back_a: assert property (ok && !ext_bus_mode |=> p2_oe_n == ~$past(p2_dir) &&
    (p2_out & ~p2_oe_n) == ($past(p2_data) & ~p2_oe_n)) else $error("gpio");
endmodule
bind ppfm_top ppfm_assertions #(.W(W)) chk (.*);

// *** verif/ppfm_partner.sv ***
`timescale 1ns/10ps
// ****
// external bus device
// ****
module ppfm_partner (
  input wire logic clk,
  input wire logic hold_req,
  input wire logic slow,
  input wire logic [15:0] rdata,
  input wire logic [7:0] p0_out,
  input wire logic [7:0] p0_oe_n,
  input wire logic [7:0] p1_out,
  input wire logic [7:0] p1_oe_n,
  input wire logic [7:0] p3_out,
  input wire logic [7:0] p3_oe_n,
  output logic [7:0] p0_in,
  output logic [7:0] p1_in,
  output logic [7:0] p3_in
);
  logic [1:0] wait_reg = 2'h0;
  logic rdy;
  always_ff @(posedge clk) begin
    if (p3_out[1]) wait_reg <= 2'h0;
    else if (wait_reg != 2'h3) wait_reg <= wait_reg + 2'h1;
  end
  assign rdy = !slow || wait_reg == 2'h3;
  // released port0/port1 lines show fresh read data, never the last driven value
  assign p0_in = (p0_out & ~p0_oe_n) | (rdata[7:0] & p0_oe_n);
  assign p1_in = (p1_out & ~p1_oe_n) | (rdata[15:8] & p1_oe_n);
  assign p3_in = (p3_out & ~p3_oe_n) | ({1'b1, rdy, 1'b0, hold_req, 4'hA} & p3_oe_n);
endmodule

// *** verif/ppfm_tb_top.sv ***
`timescale 1ns/10ps
// ****
// pad mux bench
// ****
module ppfm_tb_top;
  logic clk, rst_n, hold_req, slow, m, bus_addr_phase, bus_data_drive, bus_ale;
  logic bus_rd_n, bus_wrl_n, bus_wrh_n, bus_hold_ack, bus_clk_out, clock_monitor_out;
  logic clock_monitor_en, ext_bus_mode, bus_hold_request, bus_ready;
  logic [2:0] mode_select_pins, sync_serial_tx, sync_serial_clock, sync_tx_en;
  logic [23:0] bus_addr, xp;
  logic [24:0] xi;
  logic [15:0] bus_wdata, rdata, bus_rdata, x [7];
  logic [1:0] async_serial_tx, async_tx_en, async_serial_clock, async_clk_out_en;
  logic [1:0] pulse_gen_outputs, pulse_out_en, async_serial_rx, async_clock_in;
  logic [1:0] capture_trigger_inputs;
  logic [7:0] p0_in, p1_in, p3_in, p4_in, p5_in, p6_in, p0_data, p0_dir, p1_data;
  logic [7:0] p1_dir, p2_data, p2_dir, p3_data, p3_dir, p4_data, p4_dir, p5_data;
  logic [7:0] p5_dir, p6_data, p6_dir, port0_pullup_select, port1_pullup_select;
  logic [7:0] port6_pullup_select, port4_open_drain_select, p0_out, p0_oe_n, p0_pull;
  logic [7:0] p1_out, p1_oe_n, p1_pull, p2_out, p2_oe_n, p3_out, p3_oe_n, p4_out;
  logic [7:0] p4_oe_n, p5_out, p5_oe_n, p6_out, p6_oe_n, p6_pull;
  int n_errors = 0;
  int cmp_count = 0;
  ppfm_top dut (.*);
  ppfm_partner far (.*);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [15:0] pk(logic [7:0] o, logic [7:0] e);
    return {o & ~e, e};
  endfunction
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic drive();
    {p0_data, p0_dir, p1_data, p1_dir} = $urandom;
    {p2_data, p2_dir, p3_data, p3_dir} = $urandom;
    {p4_data, p4_dir, p5_data, p5_dir} = $urandom;
    {p6_data, p6_dir, port0_pullup_select, port1_pullup_select} = $urandom;
    {port6_pullup_select, port4_open_drain_select, p4_in, p5_in} = $urandom;
    {p6_in, rdata} = 24'($urandom);
    bus_addr = 24'($urandom);
    {bus_wdata, bus_addr_phase, bus_data_drive, bus_ale, bus_rd_n, bus_wrl_n, bus_wrh_n,
      bus_hold_ack, bus_clk_out, hold_req, slow, clock_monitor_out, clock_monitor_en,
      async_serial_tx, async_tx_en} = $urandom;
    {async_serial_clock, async_clk_out_en, sync_serial_tx, sync_serial_clock, sync_tx_en,
      pulse_gen_outputs, pulse_out_en} = 17'($urandom);
    p4_dir = p4_dir & 8'hF6;
  endtask
  task automatic predict();
    logic [7:0] o4, e4, o5, e5, o6, e6;
    logic [15:0] lo;
    o4 = p4_data;
    e4 = ~p4_dir | (port4_open_drain_select & p4_data);
    {o5, e5, o6, e6} = {p5_data, ~p5_dir, p6_data, ~p6_dir};
    if (async_tx_en[0]) {o4[1], e4[1]} = {async_serial_tx[0], 1'b0};
    if (async_clk_out_en[0]) {o4[2], e4[2]} = {async_serial_clock[0], 1'b0};
    if (async_tx_en[1]) {o4[4], e4[4]} = {async_serial_tx[1], 1'b0};
    if (async_clk_out_en[1]) {o4[5], e4[5]} = {async_serial_clock[1], 1'b0};
    if (pulse_out_en[0]) {o4[6], e4[6]} = {pulse_gen_outputs[0], 1'b0};
    if (pulse_out_en[1]) {o4[7], e4[7]} = {pulse_gen_outputs[1], 1'b0};
    if (sync_tx_en[0]) {o5[2:1], e5[2:1]} = {sync_serial_clock[0], sync_serial_tx[0], 2'h0};
    if (sync_tx_en[1]) {o5[5:4], e5[5:4]} = {sync_serial_clock[1], sync_serial_tx[1], 2'h0};
    if (sync_tx_en[2]) {o6[2:1], e6[2:1]} = {sync_serial_clock[2], sync_serial_tx[2], 2'h0};
    if (clock_monitor_en) {o6[3], e6[3]} = {clock_monitor_out, 1'b0};
    {x[4], x[5], x[6]} = {pk(o4, e4), pk(o5, e5), pk(o6, e6)};
    lo = bus_addr_phase ? bus_addr[15:0] : bus_wdata;
    x[0] = pk(p0_data, ~p0_dir);
    x[1] = pk(p1_data, ~p1_dir);
    x[2] = m ? pk(bus_addr[23:16], 8'h00) : pk(p2_data, ~p2_dir);
    x[3] = m ? pk({bus_clk_out, 1'b0, bus_hold_ack, 1'b0, bus_wrh_n, bus_wrl_n, bus_rd_n,
      bus_ale}, 8'h50) : pk(p3_data, ~p3_dir);
    if (m) {x[1], x[0]} = {pk(lo[15:8], 8'h00), pk(lo[7:0], 8'h00)};
    if (m && !bus_addr_phase && !bus_data_drive) {x[1], x[0]} = {2{pk(8'h00, 8'hFF)}};
    xp = {port6_pullup_select & e6, m ? 16'h0000 :
      {port1_pullup_select & ~p1_dir, port0_pullup_select & ~p0_dir}};
    xi = {m, m & p3_in[4], m & p3_in[6], p5_in[7:6], p4_in[3], p4_in[0], p4_in[5],
      p4_in[2], p1_in, p0_in};
  endtask
  task automatic compare();
    chk("port0", pk(p0_out, p0_oe_n), x[0]);
    chk("port1", pk(p1_out, p1_oe_n), x[1]);
    chk("port2", pk(p2_out, p2_oe_n), x[2]);
    chk("port3", pk(p3_out, p3_oe_n), x[3]);
    chk("port4", pk(p4_out, p4_oe_n), x[4]);
    chk("port5", pk(p5_out, p5_oe_n), x[5]);
    chk("port6", pk(p6_out, p6_oe_n), x[6]);
    chk("pulls", {p6_pull, p1_pull, p0_pull}, xp);
    chk("inputs", {ext_bus_mode, bus_hold_request, bus_ready, capture_trigger_inputs,
      async_serial_rx, async_clock_in, bus_rdata}, xi);
  endtask
  task automatic end_sim();
    $display("comparisons %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // about 500 cycles expected; generous margin
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_sim();
  end
  initial begin
    void'($urandom(32'h8fe8));
    {rst_n, m, mode_select_pins} = 5'h00;
    drive();
    for (int c = 0; c < 8; c++) begin
      mode_select_pins = 3'(c);
      rst_n = 1'b0;
      repeat (c == 0 ? 5 : 2) @(negedge clk);
      rst_n = 1'b1;
      m = c != 0;
      for (int k = 0; k < 60; k++) begin
        @(negedge clk);
        if (k > 1) compare();
        if (k == 30) mode_select_pins = ~mode_select_pins;
        drive();
        #1 predict();
      end
    end
    end_sim();
  end
endmodule
